// File: dv/nvm_access_ctrl_props.sv
`timescale 1ns/1ps
module nvm_access_ctrl_props (
   input wire logic clk, // Clock
   input wire logic sys_rst, // Reset
   input wire logic psel, // Select
   input wire logic penable, // Enable
   input wire logic pwrite, // Direction
   input wire logic [7:0] paddr, // Address
   input wire logic [31:0] pwdata, // Write data
   input wire logic [31:0] prdata, // Read data
   input wire logic pready, // Ready
   input wire logic pslverr, // Error
   input wire logic write_done_irq // Done irq
);
   import nvm_ctrl_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic [7:0] lo_q; // Shadow pointer low
   logic [7:0] hi_q; // Shadow pointer high
   logic ie_q; // Shadow irq enable
   wire wr_ok = pready && pwrite && !pslverr; // Write taking effect
   wire rd_ctl = pready && !pwrite && paddr == OFS_INDIRECT; // Control read
   // Mirror what software wrote, so reads can be judged
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lo_q <= '0;
         hi_q <= '0;
         ie_q <= 1'b0;
      end else if (wr_ok) begin
         if (paddr == OFS_PTR_LO) lo_q <= pwdata[7:0];
         if (paddr == OFS_PTR_HI) hi_q <= pwdata[7:0];
         if (paddr == OFS_STATUS) ie_q <= pwdata[BIT_DONE_IE];
      end
   end
   property p_ready_setup;
      pready |-> $past(psel && !penable) && psel && penable;
   endproperty
   a_ready_setup: assert property (p_ready_setup) else $error("ready outside access phase");
   property p_ready_once;
      pready |=> !pready;
   endproperty
   a_ready_once: assert property (p_ready_once) else $error("ready held two cycles");
   property p_err_map;
      pready |-> pslverr == (paddr[7:2] > 6'h05);
   endproperty
   a_err_map: assert property (p_err_map) else $error("error flag wrong for address");
   property p_rst_quiet;
      disable iff (1'b0) $past(sys_rst) |-> !pready && !pslverr && !write_done_irq;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("output active after reset");
   property p_ptr_block;
      rd_ctl && !(lo_q == CTRL_PTR_LO && hi_q == CTRL_PTR_HI) |-> prdata == '0;
   endproperty
   a_ptr_block: assert property (p_ptr_block) else $error("control reached without pointer");
   property p_ctrl_width;
      rd_ctl |-> prdata[31:4] == '0;
   endproperty
   a_ctrl_width: assert property (p_ctrl_width) else $error("control upper bits set");
   property p_addr_width;
      pready && !pwrite && paddr == OFS_ADDR |-> prdata[31:6] == '0;
   endproperty
   a_addr_width: assert property (p_addr_width) else $error("address wider than six bits");
   property p_start_permit;
      rd_ctl |-> !(prdata[2] && !prdata[3]) && !(prdata[0] && !prdata[1]);
   endproperty
   a_start_permit: assert property (p_start_permit) else $error("start without permit");
   property p_irq_enable;
      write_done_irq |-> $past(ie_q);
   endproperty
   a_irq_enable: assert property (p_irq_enable) else $error("irq while disabled");
endmodule
bind nvm_access_ctrl nvm_access_ctrl_props u_nvm_access_ctrl_props (.clk(clk), .sys_rst(sys_rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .write_done_irq(write_done_irq));

// File: dv/tb_nvm_access_ctrl.sv
`timescale 1ns/1ps
module tb_nvm_access_ctrl;
   import nvm_ctrl_pkg::*;
   logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0; // Bench drives
   logic [7:0] paddr = '0; // Address
   logic [31:0] pwdata = '0; // Write data
   logic [31:0] prdata, rd_q; // Read data, last taken
   logic pready, pslverr, write_done_irq, err_q; // Outputs, last error
   int mismatches = 0, total_checks = 0, cycles = 0, n; // Counters
   typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] e;} row_t;
   // Write then read back: offset, value, expected
   row_t rows [8] = '{'{OFS_ADDR, 32'hFF, 32'h3F},
      '{OFS_DATA, 32'hA5, 32'hA5}, '{OFS_PTR_LO, 32'h40, 32'h40}, '{OFS_PTR_HI, 32'h00, 32'h00},
      '{OFS_INDIRECT, 32'h0A, 32'h00},
      '{OFS_PTR_HI, 32'h01, 32'h01}, '{OFS_INDIRECT, 32'h02, 32'h02},
      '{OFS_INDIRECT, 32'h00, 32'h00}};
   always #4 clk = ~clk;
   nvm_access_ctrl u_nvm_access_ctrl (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .write_done_irq(write_done_irq));
   // Cut a hang short, well above the longest run
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         conclude();
      end
   end
   task automatic conclude();
      if (mismatches == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   // One APB transfer; request held until ready is sampled
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   // Poll a control bit until clear; limit guards a stuck bit
   task automatic poll(int b);
      n = 0;
      do begin
         apb(0, OFS_INDIRECT, 0);
         n++;
      end while (rd_q[b] === 1'b1 && n < 400);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      sys_rst <= 0;
      for (int i = 0; i < 6; i++) begin
         apb(0, 8'(i * 4), 0);
         chk("reset value", 0, rd_q);
      end
      foreach (rows[i]) begin
         apb(1, rows[i].a, rows[i].w);
         apb(0, rows[i].a, 0);
         chk("register row", rows[i].e, rd_q);
      end
      apb(1, OFS_INDIRECT, 32'h4);
      apb(0, OFS_INDIRECT, 0);
      chk("write start no permit", 0, rd_q);
      apb(1, OFS_INDIRECT, 32'h1);
      apb(0, OFS_INDIRECT, 0);
      chk("read start no permit", 0, rd_q);
      // Full write at the top address, irq enabled once the cycle runs
      apb(1, OFS_STATUS, 32'h0);
      apb(1, OFS_ADDR, 32'h3F);
      apb(1, OFS_DATA, 32'h5A);
      apb(1, OFS_INDIRECT, 32'h8);
      apb(1, OFS_INDIRECT, 32'hC);
      apb(1, OFS_STATUS, 32'h2);
      poll(BIT_WR_START);
      chk("write busy polls", 1, n > 1 && n < 400);
      repeat (2) @(posedge clk);
      chk("done irq", 1, write_done_irq);
      apb(0, OFS_STATUS, 0);
      chk("done flag", 32'h3, rd_q);
      apb(1, OFS_STATUS, 32'h3);
      apb(0, OFS_STATUS, 0);
      chk("flag cleared", 32'h2, rd_q);
      // Read back after clobbering the data register
      apb(1, OFS_DATA, 0);
      apb(1, OFS_INDIRECT, 32'h2);
      apb(1, OFS_INDIRECT, 32'h3);
      poll(BIT_RD_START);
      apb(0, OFS_DATA, 0);
      chk("read back", 32'h5A, rd_q);
      apb(0, OFS_DATA, 0);
      chk("data holds", 32'h5A, rd_q);
      // Both starts in one write are refused, permits still taken
      apb(1, OFS_INDIRECT, 32'hA);
      apb(1, OFS_INDIRECT, 32'hF);
      apb(0, OFS_INDIRECT, 0);
      chk("both starts", 32'hA, rd_q);
      // Halt in mid-write must abort it
      apb(1, OFS_DATA, 32'h11);
      apb(1, OFS_INDIRECT, 32'h8);
      apb(1, OFS_INDIRECT, 32'hC);
      apb(1, OFS_STATUS, 32'h4);
      poll(BIT_WR_START);
      chk("halt aborts", 1, n < 5);
      apb(1, OFS_STATUS, 0);
      apb(1, OFS_INDIRECT, 32'h2);
      apb(1, OFS_INDIRECT, 32'h3);
      poll(BIT_RD_START);
      apb(0, OFS_DATA, 0);
      chk("aborted write", 32'h5A, rd_q);
      // Pointer high cleared locks the control register
      apb(1, OFS_INDIRECT, 0);
      apb(1, OFS_PTR_HI, 0);
      apb(1, OFS_INDIRECT, 32'h8);
      apb(1, OFS_PTR_HI, 32'h1);
      apb(0, OFS_INDIRECT, 0);
      chk("blocked write", 0, rd_q);
      apb(1, 8'h18, 32'hFF);
      chk("unmapped write", 1, err_q);
      apb(0, 8'hFC, 0);
      chk("unmapped read", 1, err_q);
      conclude();
   end
endmodule

// File: rtl/nvm_access_ctrl.sv
// Operation
// - Halt before completion fails the operation
// - Pointer high zero blocks control access
// - Read permit then read start
// - Poll read start clear, then data
// - Load address, data, permit, then start
// - Poll write start until cleared
// - Zero control write clears permits
// - Read start self-clears, data holds
// - Start ignored without matching permit
// - Write end sets done flag
// - Address six bits, 00 to 3F
`timescale 1ns/1ps
module nvm_access_ctrl (
   input wire logic clk, // System clock
   input wire logic sys_rst, // Synchronous reset, high
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   output logic write_done_irq // Done flag gated by enable
);
   import nvm_ctrl_pkg::*;

   // Software-visible registers; the array itself sits in the engine
   logic [ADDR_W-1:0] nvm_address_reg_q; // Cell address
   logic [7:0] nvm_data_reg_q; // Data byte
   logic [7:0] pointer_low_byte_q; // Pointer low
   logic [7:0] pointer_high_byte_q; // Pointer high
   logic read_permit_q; // Read permit bit
   logic read_start_q; // Read busy bit
   logic write_permit_q; // Write permit bit
   logic write_start_q; // Write busy bit
   logic write_done_flag_q; // Sticky write done
   logic done_ie_q; // Done interrupt enable
   logic halt_q; // Power mode halt request
   cell_req_t req_q; // Start pulse to engine
   cell_rsp_t rsp; // Engine completion

   // Access phase qualifiers
   logic acc;
   logic wr_acc;
   logic ctrl_sel;
   logic [3:0] wctl;
   // Writes act only together with ready, at the end of the access phase
   assign acc = psel && penable;
   assign wr_acc = acc && pwrite;
   // Control register visible only through pointer 01:40
   assign ctrl_sel = (pointer_high_byte_q == CTRL_PTR_HI) && (pointer_low_byte_q == CTRL_PTR_LO);
   assign wctl = pwdata[3:0];

   // Word-address match against a register offset
   // Low two address bits are ignored, each register is one word
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a[7:2] == ofs[7:2]);
   endfunction

   // Whether an address is mapped
   // Six words are decoded, everything else answers with an error
   function automatic logic mapped(input logic [7:0] a);
      mapped = hit(a, OFS_ADDR) || hit(a, OFS_DATA) || hit(a, OFS_PTR_LO) || hit(a, OFS_PTR_HI)
         || hit(a, OFS_INDIRECT) || hit(a, OFS_STATUS);
   endfunction

   // Control write decode; the pointer must select the control register
   logic ind_wr; // Write that lands in the control register
   assign ind_wr = wr_acc && hit(paddr, OFS_INDIRECT) && ctrl_sel;

   // Busy decode; new starts are refused while this is high
   logic busy; // Any operation in flight
   assign busy = read_start_q || write_start_q;

   // Zero-wait slave; unmapped addresses answer with an error
   // Ready rises in the access phase only, since setup always comes first
   // Error is decided at setup so it stands beside ready in the same cycle
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !pready;
         pslverr <= psel && !pready && !mapped(paddr);
      end
   end

   // Read data mux, registered for the access edge
   // Captured at setup and again in access; the master takes it with ready
   // Unused bits read zero so software may compare whole words
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prdata <= '0;
      end else if (psel && !pwrite) begin
         prdata <= '0;
         if (hit(paddr, OFS_ADDR)) prdata[ADDR_W-1:0] <= nvm_address_reg_q;
         if (hit(paddr, OFS_DATA)) prdata[7:0] <= nvm_data_reg_q;
         if (hit(paddr, OFS_PTR_LO)) prdata[7:0] <= pointer_low_byte_q;
         if (hit(paddr, OFS_PTR_HI)) prdata[7:0] <= pointer_high_byte_q;
         // Off-sector pointers read zero through the port
         if (hit(paddr, OFS_INDIRECT) && ctrl_sel) begin
            prdata[3:0] <= {write_permit_q, write_start_q, read_permit_q, read_start_q};
         end
         if (hit(paddr, OFS_STATUS)) begin
            prdata[2:0] <= {halt_q, done_ie_q, write_done_flag_q};
         end
      end
   end

   // Direct byte registers; the data byte also takes read results
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         nvm_address_reg_q <= '0;
         nvm_data_reg_q <= BYTE_RST;
         pointer_low_byte_q <= BYTE_RST;
         pointer_high_byte_q <= BYTE_RST;
      end else begin
         // Address keeps six bits; upper write bits are dropped
         if (wr_acc && hit(paddr, OFS_ADDR) && pready) begin
            nvm_address_reg_q <= pwdata[ADDR_W-1:0];
         end
         // Pointer low byte selects the word within a sector
         if (wr_acc && hit(paddr, OFS_PTR_LO) && pready) begin
            pointer_low_byte_q <= pwdata[7:0];
         end
         // Pointer high byte selects the sector; zero locks control
         if (wr_acc && hit(paddr, OFS_PTR_HI) && pready) begin
            pointer_high_byte_q <= pwdata[7:0];
         end
         // Result from the cell wins; it stays until the next read result or data register write
         if (rsp.done && !rsp.failed && rsp.kind == OP_READ) begin
            nvm_data_reg_q <= rsp.rdata;
         end else if (wr_acc && hit(paddr, OFS_DATA) && pready) begin
            nvm_data_reg_q <= pwdata[7:0];
         end
      end
   end

   // Permit bits; a zero write clears both
   // Permits are written by every control write, start bits or not
   // Clearing a permit does not stop a cycle already running
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         read_permit_q <= CTRL_RST[BIT_RD_PERMIT];
         write_permit_q <= CTRL_RST[BIT_WR_PERMIT];
      end else if (ind_wr && pready) begin
         read_permit_q <= wctl[BIT_RD_PERMIT];
         write_permit_q <= wctl[BIT_WR_PERMIT];
      end
   end

   // Start bits: set only with a permit already held, cleared by hardware
   // The start request is a one-cycle pulse; the engine latches it
   // Address and data are taken at the start edge, later writes leave the cycle alone
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         read_start_q <= CTRL_RST[BIT_RD_START];
         write_start_q <= CTRL_RST[BIT_WR_START];
         req_q <= '0;
      end else begin
         req_q <= '0;
         // Completion clears the matching start bit, clean or failed
         if (rsp.done && rsp.kind == OP_READ) read_start_q <= 1'b0;
         if (rsp.done && rsp.kind == OP_WRITE) write_start_q <= 1'b0;
         // One start at a time; both starts together are ignored
         // Busy blocks a second start so the engine never sees two requests
         if (ind_wr && pready && !busy && !(wctl[BIT_RD_START] && wctl[BIT_WR_START])) begin
            if (wctl[BIT_RD_START] && read_permit_q) begin
               read_start_q <= 1'b1;
               req_q <= '{kind: OP_READ, addr: nvm_address_reg_q, wdata: nvm_data_reg_q};
            end
            if (wctl[BIT_WR_START] && write_permit_q) begin
               write_start_q <= 1'b1;
               req_q <= '{kind: OP_WRITE, addr: nvm_address_reg_q, wdata: nvm_data_reg_q};
            end
         end
      end
   end

   // Status bits; a new done event wins over a software clear
   // Halt stands for idle or sleep entry and aborts work in flight
   // Done flag: writing one clears it, a completion in that cycle keeps it set
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         write_done_flag_q <= 1'b0;
         done_ie_q <= 1'b0;
         halt_q <= 1'b0;
      end else begin
         if (wr_acc && hit(paddr, OFS_STATUS) && pready) begin
            if (pwdata[BIT_DONE_FLAG]) write_done_flag_q <= 1'b0;
            done_ie_q <= pwdata[BIT_DONE_IE];
            halt_q <= pwdata[BIT_HALT];
         end
         if (rsp.done && rsp.kind == OP_WRITE) write_done_flag_q <= 1'b1;
      end
   end

   // Interrupt request output, registered
   // Costs one cycle of latency, but keeps the output glitch free
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         write_done_irq <= 1'b0;
      end else begin
         write_done_irq <= write_done_flag_q && done_ie_q;
      end
   end

   // Cell timing and array
   // Engine owns the array; its contents are not cleared by reset
   nvm_cell_engine u_engine (
      .clk(clk),
      .sys_rst(sys_rst),
      .req(req_q),
      .halt(halt_q),
      .rsp(rsp)
   );

endmodule

// File: rtl/nvm_cell_engine.sv
`timescale 1ns/1ps
module nvm_cell_engine (
   input wire logic clk, // System clock
   input wire logic sys_rst, // Synchronous reset, high
   input wire nvm_ctrl_pkg::cell_req_t req, // One-cycle start request
   input wire logic halt, // Power mode halt request
   output nvm_ctrl_pkg::cell_rsp_t rsp // One-cycle completion
);
   import nvm_ctrl_pkg::*;

   // States of the cell cycle
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_BUSY
   } cell_state_t;

   logic [7:0] mem_q [DEPTH]; // Cell array
   cell_state_t state_q; // Engine state
   cell_req_t cur_q; // Operation in flight
   logic [CNT_W-1:0] cnt_q; // Remaining cycles

   // Cycle count for one operation kind
   function automatic logic [CNT_W-1:0] op_cycles(input op_kind_t k);
      op_cycles = (k == OP_WRITE) ? CNT_W'(WRITE_CYC) : CNT_W'(READ_CYC);
   endfunction

   // Sequencer; a halt mid-cycle aborts without touching the cell
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q <= ST_IDLE;
         cur_q <= '0;
         cnt_q <= '0;
         rsp <= '0;
      end else begin
         rsp <= '0;
         case (state_q)
            ST_IDLE: begin
               if (req.kind != OP_NONE) begin
                  state_q <= ST_BUSY;
                  cur_q <= req;
                  cnt_q <= op_cycles(req.kind);
               end
            end
            ST_BUSY: begin
               if (halt) begin
                  state_q <= ST_IDLE;
                  rsp.done <= 1'b1;
                  rsp.failed <= 1'b1;
                  rsp.kind <= cur_q.kind;
               end else if (cnt_q == CNT_W'(1)) begin
                  state_q <= ST_IDLE;
                  rsp.done <= 1'b1;
                  rsp.kind <= cur_q.kind;
                  rsp.rdata <= (cur_q.kind == OP_WRITE) ? cur_q.wdata : mem_q[cur_q.addr];
               end else begin
                  cnt_q <= cnt_q - CNT_W'(1);
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Array update at the end of a clean write; contents survive reset
   always_ff @(posedge clk) begin
      if (!sys_rst && state_q == ST_BUSY && !halt && cnt_q == CNT_W'(1) && cur_q.kind == OP_WRITE) begin
         mem_q[cur_q.addr] <= cur_q.wdata;
      end
   end

endmodule

// File: rtl/nvm_ctrl_pkg.sv
package nvm_ctrl_pkg;

   // Register byte offsets on the APB
   localparam logic [7:0] OFS_ADDR = 8'h00;     // Address register
   localparam logic [7:0] OFS_DATA = 8'h04;     // Data register
   localparam logic [7:0] OFS_PTR_LO = 8'h08;   // Pointer low byte
   localparam logic [7:0] OFS_PTR_HI = 8'h0C;   // Pointer high byte
   localparam logic [7:0] OFS_INDIRECT = 8'h10; // Indirect access port
   localparam logic [7:0] OFS_STATUS = 8'h14;   // Flag and power mode

   // Pointer value that selects the control register
   localparam logic [7:0] CTRL_PTR_LO = 8'h40;
   localparam logic [7:0] CTRL_PTR_HI = 8'h01;

   // Control register bit positions
   localparam int BIT_RD_START = 0;
   localparam int BIT_RD_PERMIT = 1;
   localparam int BIT_WR_START = 2;
   localparam int BIT_WR_PERMIT = 3;

   // Status register bit positions
   localparam int BIT_DONE_FLAG = 0;
   localparam int BIT_DONE_IE = 1;
   localparam int BIT_HALT = 2;

   // Array geometry
   localparam int ADDR_W = 6;
   localparam int DEPTH = 64;

   // Reset values
   localparam logic [3:0] CTRL_RST = 4'h0;
   localparam logic [7:0] BYTE_RST = 8'h00;

   // Cell timing
   localparam int CLK_MHZ = 125;
   localparam int READ_NS = 40;
   localparam int WRITE_US = 4;
   localparam int READ_CYC = (READ_NS * CLK_MHZ + 999) / 1000;
   localparam int WRITE_CYC = WRITE_US * CLK_MHZ;
   localparam int CNT_W = 12;

   // Cell operation kinds
   typedef enum logic [1:0] {
      OP_NONE,
      OP_READ,
      OP_WRITE
   } op_kind_t;

   // Request handed to the cell engine
   typedef struct packed {
      op_kind_t kind;
      logic [ADDR_W-1:0] addr;
      logic [7:0] wdata;
   } cell_req_t;

   // Result coming back from the cell engine
   typedef struct packed {
      logic done;
      logic failed;
      op_kind_t kind;
      logic [7:0] rdata;
   } cell_rsp_t;

endpackage
